// ==== core/fars_supervisor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fars_consts.svh"

// Decides whether and when the motor may be energized after trips,
// run requests and power-up.
module fars_supervisor
  import fars_pkg::*;
#(
  parameter int TICK_CYCLES = `FARS_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic restart_en,
  input wire fars_cfg_s cfg,
  input wire logic [11:0] ext_fault,
  input wire logic dry_well_cond,
  input wire logic loop_signal_ok,
  input wire logic run_manual,
  input wire logic stop_manual,
  input wire logic run_ext,
  output fars_stat_s stat
);

  initial begin
    if (TICK_CYCLES < 2) begin
      $error("fars_supervisor: TICK_CYCLES must be at least 2");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Restart counting class of each trip source.
  function automatic logic [3:0] src_class(input logic [3:0] s);
    case (s)
      `FARS_SRC_CLASS10, `FARS_SRC_OC_IN, `FARS_SRC_CS_HIGH:
        src_class = `FARS_CLS_OVL;
      `FARS_SRC_SYS_OVL: src_class = `FARS_CLS_SYS;
      `FARS_SRC_BUS_OV: src_class = `FARS_CLS_BUS;
      `FARS_SRC_DRY_CUR, `FARS_SRC_LOW_PWR: src_class = `FARS_CLS_DRY;
      `FARS_SRC_UNBAL: src_class = `FARS_CLS_IMB;
      `FARS_SRC_LOW_V: src_class = `FARS_CLS_UV;
      `FARS_SRC_HIGH_V: src_class = `FARS_CLS_OV;
      `FARS_SRC_PHASE: src_class = `FARS_CLS_PH;
      default: src_class = `FARS_CLS_SNS;
    endcase
  endfunction : src_class

  // Delay group of each trip source.
  function automatic logic [1:0] src_group(input logic [3:0] s);
    case (s)
      `FARS_SRC_CLASS10, `FARS_SRC_OC_IN, `FARS_SRC_SYS_OVL:
        src_group = 2'h0;
      `FARS_SRC_BUS_OV, `FARS_SRC_DRY_CUR, `FARS_SRC_UNBAL,
      `FARS_SRC_LOW_PWR:
        src_group = 2'h1;
      default: src_group = 2'h2;
    endcase
  endfunction : src_group

  // Timer step: counts a second up towards a limit, saturating there.
  function automatic logic [13:0] step_up(input logic [13:0] c,
                                          input logic [13:0] lim,
                                          input logic t);
    step_up = (t && c < lim) ? c + 14'h0001 : c;
  endfunction : step_up

  ////////////////////////////////////////////////////////////////////////////
  // Second tick.

  logic tick; // One-cycle pulse per second.

  fars_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Condition monitors: dry well and loop signal loss.

  logic [13:0] dw_cnt_q, dw_cnt_d; // Seconds the dry well has lasted.
  logic [13:0] sn_cnt_q, sn_cnt_d; // Seconds the loop signal is absent.
  logic dw_trip_q, dw_trip_d;
  logic sn_trip_q, sn_trip_d;

  // Both timers restart from zero as soon as the condition clears, so
  // only an unbroken condition can reach the trip point.
  always_comb begin
    dw_cnt_d = dry_well_cond ?
               step_up(dw_cnt_q, cfg.dry_well_delay, tick) : 14'h0000;
    dw_trip_d = dry_well_cond && dw_cnt_q >= cfg.dry_well_delay;
    sn_cnt_d = !loop_signal_ok ?
               step_up(sn_cnt_q, cfg.sensor_delay, tick) : 14'h0000;
    sn_trip_d = !loop_signal_ok && sn_cnt_q >= cfg.sensor_delay;
  end

  // Register the monitors.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dw_cnt_q <= 14'h0000;
      sn_cnt_q <= 14'h0000;
      dw_trip_q <= 1'b0;
      sn_trip_q <= 1'b0;
    end else begin
      dw_cnt_q <= dw_cnt_d;
      sn_cnt_q <= sn_cnt_d;
      dw_trip_q <= dw_trip_d;
      sn_trip_q <= sn_trip_d;
    end
  end

  // Internal trips enter as one-cycle pulses on their rising edge.
  logic [11:0] trip_src;
  always_comb begin
    trip_src = ext_fault;
    trip_src[`FARS_SRC_DRY_CUR] = ext_fault[`FARS_SRC_DRY_CUR] |
                                  (dw_trip_d & ~dw_trip_q);
    trip_src[`FARS_SRC_SENSOR] = ext_fault[`FARS_SRC_SENSOR] |
                                 (sn_trip_d & ~sn_trip_q);
  end

  // The lowest numbered source wins when several trip together.
  logic fault_any;
  logic [3:0] fault_idx;
  always_comb begin
    fault_any = |trip_src;
    fault_idx = 4'h0;
    for (int i = `FARS_NSRC - 1; i >= 0; i--) begin
      if (trip_src[i]) begin
        fault_idx = 4'(i);
      end
    end
  end

  logic [3:0] fault_cls;
  logic [13:0] grp_delay;
  assign fault_cls = src_class(fault_idx);
  assign grp_delay = cfg.restart_delay[src_group(fault_idx)];

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor state machine.

  fars_state_e state_q, state_d;
  logic [13:0] sec_q, sec_d; // Countdown shared by the timed states.
  logic [8:0][13:0] rcnt_q, rcnt_d; // Restarts used per class.
  logic [3:0] starts_q, starts_d; // Startup attempts this power cycle.
  logic [19:0] elap_q, elap_d; // Seconds since power-up, saturating.
  fars_stat_s stat_q, stat_d;
  logic starts_ok;
  logic stop_req;
  logic restart_ok;
  fars_state_e mode_st;

  // Start attempts and elapsed time are both bounded per power cycle;
  // zero in either setting means no bound.
  assign starts_ok =
    (cfg.startups_per_cycle == 4'h0 ||
     starts_q < cfg.startups_per_cycle) &&
    (cfg.max_cycle_time == 20'h0_0000 ||
     elap_q < cfg.max_cycle_time);
  assign mode_st = restart_en ? ST_AUTO : ST_OFF;
  assign stop_req = (state_q == ST_OFF || !restart_en) ? stop_manual
                                                        : !run_ext;
  // A class with no restarts left keeps the drive tripped.
  assign restart_ok = restart_en &&
                      rcnt_q[fault_cls] < cfg.restart_limit[fault_cls];

  always_comb begin
    state_d = state_q;
    sec_d = sec_q;
    rcnt_d = rcnt_q;
    starts_d = starts_q;
    elap_d = (tick && elap_q != 20'hF_FFFF) ? elap_q + 20'h0_0001 : elap_q;
    if (fault_any && state_q != ST_INIT && state_q != ST_LOCKED) begin
      // A new trip also replaces a pending delay with its own group.
      if (restart_ok) begin
        state_d = ST_WAIT;
        sec_d = grp_delay;
        rcnt_d[fault_cls] = rcnt_q[fault_cls] + 14'h0001;
      end else begin
        state_d = ST_LOCKED;
      end
    end else begin
      case (state_q)
        ST_INIT: begin
          // First cycle after power-up loads the startup delay.
          state_d = ST_PWRUP;
          sec_d = cfg.startup_delay;
        end
        ST_PWRUP: begin
          if (sec_q == 14'h0000) begin
            state_d = mode_st;
          end else if (tick) begin
            sec_d = sec_q - 14'h0001;
          end
        end
        ST_OFF, ST_AUTO: begin
          // Manual run starts the hold-off in either mode, but in auto it is dropped again unless run_ext is high; external run only in auto.
          if (state_q == ST_AUTO && !restart_en) begin
            state_d = ST_OFF;
          end else if (run_manual ||
                       (state_q == ST_AUTO && run_ext)) begin
            state_d = starts_ok ? ST_HOLDOFF : ST_LOCKED;
            sec_d = 14'(cfg.short_cycle_delay);
          end
        end
        ST_HOLDOFF: begin
          if (stop_req) begin
            state_d = mode_st;
          end else if (sec_q == 14'h0000) begin
            state_d = ST_RUN;
            starts_d = starts_q + 4'h1;
          end else if (tick) begin
            sec_d = sec_q - 14'h0001;
          end
        end
        ST_RUN: begin
          if (stop_req) begin
            state_d = mode_st;
          end
        end
        ST_WAIT: begin
          // Disabling restarts drops the pending restart at once.
          if (!restart_en) begin
            state_d = ST_OFF;
          end else if (sec_q == 14'h0000) begin
            state_d = ST_AUTO;
          end else if (tick) begin
            sec_d = sec_q - 14'h0001;
          end
        end
        ST_LOCKED: state_d = ST_LOCKED;
        default: state_d = ST_INIT;
      endcase
    end
    // Status mirrors the next state so it lines up with state_q.
    stat_d = '0;
    stat_d.motor_on = state_d == ST_RUN;
    stat_d.auto_mode = state_d == ST_AUTO;
    stat_d.off_mode = state_d == ST_OFF;
    stat_d.restart_pending = state_d == ST_WAIT;
    stat_d.locked_out = state_d == ST_LOCKED;
    stat_d.dry_well_trip = dw_trip_d;
    stat_d.sensor_fault = sn_trip_d;
    stat_d.holdoff_left = (state_d == ST_HOLDOFF) ? sec_d[8:0]
                                                  : 9'h000;
    stat_d.restart_left = (state_d == ST_WAIT) ? sec_d : 14'h0000;
  end

  // Counters clear only through reset, which is the power cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_INIT;
      sec_q <= 14'h0000;
      rcnt_q <= '0;
      starts_q <= 4'h0;
      elap_q <= 20'h0_0000;
      stat_q <= '0;
    end else begin
      state_q <= state_d;
      sec_q <= sec_d;
      rcnt_q <= rcnt_d;
      starts_q <= starts_d;
      elap_q <= elap_d;
      stat_q <= stat_d;
    end
  end

  assign stat = stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_OFF_AT_INIT: assert property (@(posedge mclk)
    disable iff (!rst_n) state_q == ST_PWRUP && sec_q == 14'h0000 &&
    !fault_any && !restart_en |=> state_q == ST_OFF && stat.off_mode)
    else $error("power-up did not settle in OFF");

  AST_AUTO_AT_INIT: assert property (@(posedge mclk)
    disable iff (!rst_n) state_q == ST_PWRUP && sec_q == 14'h0000 &&
    !fault_any && restart_en |=> state_q == ST_AUTO)
    else $error("power-up did not settle in auto mode");

  AST_DRY_WELL_TIME: assert property (@(posedge mclk)
    disable iff (!rst_n) $rose(dw_trip_q) |-> $past(dry_well_cond) &&
    $past(dw_cnt_q) >= $past(cfg.dry_well_delay))
    else $error("dry well tripped early");

  AST_SENSOR_TIME: assert property (@(posedge mclk)
    disable iff (!rst_n) $rose(stat.sensor_fault) |->
    !$past(loop_signal_ok) && $past(sn_cnt_q) >= $past(cfg.sensor_delay))
    else $error("sensor fault raised early");

  AST_GROUP_DELAY: assert property (@(posedge mclk)
    disable iff (!rst_n) fault_any && restart_ok && state_q != ST_INIT &&
    state_q != ST_LOCKED |=> state_q == ST_WAIT && sec_q == $past(grp_delay))
    else $error("restart delay not loaded from the trip group");

  AST_EXHAUSTED: assert property (@(posedge mclk)
    disable iff (!rst_n) fault_any && !restart_ok && state_q != ST_INIT
    |=> state_q == ST_LOCKED [*2])
    else $error("exhausted class did not stay tripped");

  AST_MOTOR_ONLY_RUN: assert property (@(posedge mclk)
    disable iff (!rst_n) stat.motor_on |-> state_q == ST_RUN &&
    $past(state_q) != ST_OFF && $past(state_q) != ST_AUTO)
    else $error("motor energized without hold-off");

  AST_COUNTDOWN: assert property (@(posedge mclk)
    disable iff (!rst_n) state_q == ST_HOLDOFF && tick &&
    sec_q != 14'h0000 && !fault_any && !stop_req
    |=> stat.holdoff_left == 9'($past(sec_q) - 14'h0001))
    else $error("hold-off countdown wrong");

  AST_CANCEL: assert property (@(posedge mclk)
    disable iff (!rst_n) state_q == ST_WAIT && !restart_en && !fault_any
    |=> state_q == ST_OFF && !stat.restart_pending)
    else $error("pending restart not cancelled");

  AST_START_LIMIT: assert property (@(posedge mclk)
    disable iff (!rst_n) $rose(stat.motor_on) |->
    cfg.startups_per_cycle == 4'h0 || starts_q <= cfg.startups_per_cycle)
    else $error("too many startup attempts");

endmodule : fars_supervisor
`default_nettype wire

// ==== common/fars_consts.svh ====
// Contract
// - Restarts off: never self-restart, start OFF
// - Restarts on: start in automatic mode
// - Dry-well trips after configured continuous seconds
// - Delay group one after overload trips
// - Delay group two after bus/dry/unbalance trips
// - Delay group three after sensor/voltage trips
// - Limit restarts after motor overload trips
// - Limit restarts after dry-well trips
// - Limit restarts after current imbalance trips
// - Limit restarts after low input voltage
// - Limit restarts after high input voltage
// - Limit restarts after DC bus overvoltage
// - Wait startup delay after power cycle
// - Limit restarts after input phase loss
// - Limit restarts after sensor signal loss
// - Hold motor off after any run request
// - Hold-off for all runs, show countdown
// - Sensor fault after signal absent long enough
// - Limit startup attempts per power cycle
// - Stop startups after maximum cycle time
`ifndef FARS_CONSTS_SVH
`define FARS_CONSTS_SVH

// System clock and the one-second tick derived from it.
`define FARS_CLK_HZ 25000000
`define FARS_TICK_CYCLES (`FARS_CLK_HZ / 1)

// Field widths of the configuration and status words.
`define FARS_SEC_W 14
`define FARS_HOLD_W 9
`define FARS_STARTS_W 4
`define FARS_CYC_W 20
`define FARS_NSRC 12
`define FARS_NCLS 9
`define FARS_NGRP 3

// Trip source positions in the fault vector.
`define FARS_SRC_CLASS10 0
`define FARS_SRC_OC_IN 1
`define FARS_SRC_SYS_OVL 2
`define FARS_SRC_BUS_OV 3
`define FARS_SRC_DRY_CUR 4
`define FARS_SRC_UNBAL 5
`define FARS_SRC_LOW_PWR 6
`define FARS_SRC_CS_HIGH 7
`define FARS_SRC_LOW_V 8
`define FARS_SRC_HIGH_V 9
`define FARS_SRC_PHASE 10
`define FARS_SRC_SENSOR 11

// Restart counting classes.
`define FARS_CLS_OVL 0
`define FARS_CLS_DRY 1
`define FARS_CLS_IMB 2
`define FARS_CLS_UV 3
`define FARS_CLS_OV 4
`define FARS_CLS_BUS 5
`define FARS_CLS_PH 6
`define FARS_CLS_SNS 7
`define FARS_CLS_SYS 8

// Power-on defaults of every setting, in seconds or counts.
`define FARS_DEF_DRY_WELL 14'h0004
`define FARS_DEF_DELAY1 14'h003C
`define FARS_DEF_DELAY2 14'h000F
`define FARS_DEF_DELAY3 14'h000F
`define FARS_DEF_LIM_OVL 14'h0004
`define FARS_DEF_LIM_10 14'h000A
`define FARS_DEF_LIM_SYS 14'h0000
`define FARS_DEF_STARTUP 14'h0000
`define FARS_DEF_SHORT_CYC 9'h003
`define FARS_DEF_SENSOR 14'h000A
`define FARS_DEF_STARTS 4'h0
`define FARS_DEF_MAX_CYC 20'h0_0E10
`define FARS_MAX_STARTS 4'hA
`define FARS_MAX_CYC_LIM 20'h9_3A80

`endif

// ==== common/fars_pkg.sv ====
package fars_pkg;

  // Supervisor states.
  typedef enum logic [3:0] {
    ST_INIT, ST_PWRUP, ST_OFF, ST_AUTO, ST_HOLDOFF, ST_RUN, ST_WAIT, ST_LOCKED
  } fars_state_e;

  // Settings, held outside the block and presented as a level.
  typedef struct packed {
    logic [13:0] dry_well_delay;
    logic [2:0][13:0] restart_delay;
    logic [8:0][13:0] restart_limit;
    logic [13:0] startup_delay;
    logic [8:0] short_cycle_delay;
    logic [13:0] sensor_delay;
    logic [3:0] startups_per_cycle;
    logic [19:0] max_cycle_time;
  } fars_cfg_s;

  // Status word, all fields registered.
  typedef struct packed {
    logic motor_on;
    logic auto_mode;
    logic off_mode;
    logic restart_pending;
    logic locked_out;
    logic dry_well_trip;
    logic sensor_fault;
    logic [8:0] holdoff_left;
    logic [13:0] restart_left;
  } fars_stat_s;

endpackage : fars_pkg

// ==== core/fars_tick.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fars_consts.svh"

// Divides the system clock down to a one-cycle pulse each second.
module fars_tick
  import fars_pkg::*;
#(
  parameter int TICK_CYCLES = `FARS_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick
);

  // A divider shorter than two cycles could not produce a pulse.
  initial begin
    if (TICK_CYCLES < 2) begin
      $error("fars_tick: TICK_CYCLES must be at least 2");
    end
  end

  logic [31:0] div_q; // Cycles left before the next pulse.
  logic [31:0] div_d;
  logic tick_d;
  logic tick_q;

  // Reload on wrap; the pulse is registered so it is glitch free.
  always_comb begin
    tick_d = 1'b0;
    div_d = div_q - 32'h0000_0001;
    if (div_q == 32'h0000_0000) begin
      div_d = 32'(TICK_CYCLES - 1);
      tick_d = 1'b1;
    end
  end

  // Register the divider.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : fars_tick
`default_nettype wire

// ==== bench/fars_field.sv ====
`timescale 1ns/10ps
`default_nettype none

// Stands in for the fault detectors and the motor power stage.
module fars_field (
  input wire logic mclk,
  input wire logic motor_on,
  output logic [11:0] ext_fault,
  output logic dry_well_cond,
  output logic loop_signal_ok
);
  // Power stage side: counts how often the motor was energized.
  int starts = 0;

  initial begin
    ext_fault = 12'h000;
    dry_well_cond = 1'b0;
    loop_signal_ok = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // A detector reports a trip as a single-cycle pulse, never a level.
  task automatic trip(input int src);
    @(negedge mclk);
    ext_fault = 12'h001 << src;
    @(negedge mclk);
    ext_fault = 12'h000;
  endtask : trip

  // Levels change only at the falling edge, well away from sampling.
  task automatic set_levels(input logic dry, input logic loop_ok);
    @(negedge mclk);
    dry_well_cond = dry;
    loop_signal_ok = loop_ok;
  endtask : set_levels

  // The power stage sees each energize as one rising edge.
  always @(posedge motor_on) begin
    starts++;
  end
endmodule : fars_field

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none

// Sequences run, stop and trip requests against the supervisor.
module tb;
  import fars_pkg::*;
  localparam int TC = 8; // Short second keeps long delays affordable.
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic restart_en = 1'b0;
  logic run_manual = 1'b0;
  logic stop_manual = 1'b0;
  logic run_ext = 1'b0;
  fars_cfg_s cfg;
  fars_stat_s stat;
  wire logic [11:0] ext_fault;
  wire logic dry_well_cond;
  wire logic loop_signal_ok;
  int fails = 0;
  int comparisons = 0;
  int srcs [9] = '{0, 4, 5, 8, 9, 3, 10, 11, 2}; // One source per class.

  always #20 mclk = ~mclk;

  fars_supervisor #(.TICK_CYCLES(TC)) dut (.mclk(mclk), .rst_n(rst_n),
    .restart_en(restart_en), .cfg(cfg), .ext_fault(ext_fault),
    .dry_well_cond(dry_well_cond), .loop_signal_ok(loop_signal_ok),
    .run_manual(run_manual), .stop_manual(stop_manual), .run_ext(run_ext),
    .stat(stat));

  fars_field fld (.mclk(mclk), .motor_on(stat.motor_on),
    .ext_fault(ext_fault), .dry_well_cond(dry_well_cond),
    .loop_signal_ok(loop_signal_ok));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // One compare for every status value, four-state safe.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Steps one clock and stops at the falling edge, where outputs have
  // settled and the next input change is due.
  task automatic settle();
    @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  function automatic logic pick(input int w);
    case (w)
      0: return stat.motor_on;
      1: return stat.off_mode;
      2: return stat.auto_mode;
      3: return stat.locked_out;
      4: return stat.dry_well_trip;
      default: return stat.sensor_fault;
    endcase
  endfunction : pick

  // Bounded wait; a flag that never comes up counts as a mismatch.
  task automatic wait_bit(input int w, input int lim);
    int n;
    n = 0;
    while (pick(w) !== 1'b1 && n < lim) begin
      settle();
      n++;
    end
    chk(pick(w), 1'b1);
  endtask : wait_bit

  task automatic pulse(input int which);
    @(negedge mclk);
    if (which == 0) run_manual = 1'b1;
    else stop_manual = 1'b1;
    @(negedge mclk);
    run_manual = 1'b0;
    stop_manual = 1'b0;
  endtask : pulse

  // Models an input power cycle; counters clear only through rst_n, pulsed here.
  task automatic power_cycle(input logic en);
    @(negedge mclk);
    rst_n = 1'b0;
    restart_en = en;
    run_ext = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    wait_bit(en ? 2 : 1, 6 * TC);
  endtask : power_cycle

  task automatic defaults();
    cfg = '0;
    cfg.dry_well_delay = `FARS_DEF_DRY_WELL;
    cfg.restart_delay = {14'h0007, 14'h0006, 14'h0005};
    for (int i = 0; i < 9; i++) cfg.restart_limit[i] = `FARS_DEF_LIM_10;
    cfg.short_cycle_delay = `FARS_DEF_SHORT_CYC;
    cfg.sensor_delay = `FARS_DEF_SENSOR;
  endtask : defaults

  ////////////////////////////////////////////////////////////////////////
  initial begin
    defaults();
    power_cycle(1'b0);
    chk(stat.auto_mode, 1'b0);
    pulse(0);
    settle();
    chk(stat.holdoff_left, 32'h0000_0003);
    repeat (TC) settle();
    chk(stat.holdoff_left, 32'h0000_0002);
    wait_bit(0, 4 * TC);
    fld.trip(0);
    settle();
    chk(stat.locked_out, 1'b1);
    chk(stat.motor_on, 1'b0);
    // Each delay group loads its own figure after a trip.
    power_cycle(1'b1);
    run_ext = 1'b1;
    wait_bit(0, 6 * TC);
    for (int g = 0; g < 3; g++) begin
      fld.trip(g == 0 ? 0 : (g == 1 ? 3 : 7));
      settle();
      chk(stat.restart_pending, 1'b1);
      chk(stat.restart_left, 32'h0000_0005 + 32'(g));
      wait_bit(0, 12 * TC);
    end
    fld.trip(1);
    fld.trip(8);
    settle();
    chk(stat.restart_left, 32'h0000_0007);
    restart_en = 1'b0;
    wait_bit(1, 4);
    // Limit of one: the second trip of a class must lock out.
    cfg.restart_delay = {14'h0001, 14'h0001, 14'h0001};
    cfg.short_cycle_delay = 9'h000;
    for (int c = 0; c < 9; c++) begin
      cfg.restart_limit[c] = 14'h0001;
      power_cycle(1'b1);
      run_ext = 1'b1;
      wait_bit(0, 3 * TC);
      fld.trip(srcs[c]);
      settle();
      chk(stat.locked_out, 1'b0);
      wait_bit(0, 4 * TC);
      fld.trip(srcs[c]);
      settle();
      chk(stat.locked_out, 1'b1);
      chk(stat.motor_on, 1'b0);
      cfg.restart_limit[c] = `FARS_DEF_LIM_10;
    end
    // Monitors trip only after the full continuous span.
    cfg.dry_well_delay = 14'h0002;
    cfg.sensor_delay = 14'h0002;
    for (int m = 0; m < 2; m++) begin
      power_cycle(1'b1);
      run_ext = 1'b1;
      wait_bit(0, 3 * TC);
      // First pass dries the well only, second pass drops the loop only.
      fld.set_levels(m == 0, m == 0);
      repeat (TC) settle();
      chk(pick(4 + m), 1'b0);
      wait_bit(4 + m, 3 * TC);
      settle();
      chk(stat.motor_on, 1'b0);
      fld.set_levels(1'b0, 1'b1);
    end
    // One start allowed per power cycle.
    cfg.startups_per_cycle = 4'h1;
    power_cycle(1'b0);
    pulse(0);
    wait_bit(0, 3 * TC);
    pulse(1);
    wait_bit(1, 4);
    pulse(0);
    settle();
    chk(stat.locked_out, 1'b1);
    // A run after the cycle time has gone by is refused.
    cfg.startups_per_cycle = 4'h0;
    cfg.max_cycle_time = 20'h0_0001;
    power_cycle(1'b0);
    repeat (3 * TC) settle();
    pulse(0);
    settle();
    chk(stat.locked_out, 1'b1);
    // Startup delay holds OFF mode back after power-up.
    cfg.max_cycle_time = 20'h0_0000;
    cfg.startup_delay = 14'h0002;
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (TC) settle();
    chk(stat.off_mode, 1'b0);
    wait_bit(1, 3 * TC);
    chk(fld.starts > 0, 1'b1);
    give_verdict();
  end

  // The whole sequence needs well under this many cycles.
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    give_verdict();
  end
endmodule : tb

`default_nettype wire
